// [src/ppoc_opt_if.sv]
// option store access between the controller and the option memory
`timescale 1ns/1ps
`default_nettype none
interface ppoc_opt_if;
  import ppoc_pkg::*;
  logic wr_en;
  logic wr_port;
  logic [2:0] wr_pin;
  logic wr_dir;
  logic [2:0] wr_data;
  logic [NPORT-1:0][2:0] rd_pin;
  logic [NPORT-1:0] rd_dir;
  logic [NPORT-1:0][2:0] rd_data;
  ppoc_out_type out_opt;
  ppoc_in_type in_opt;
  modport ctrl (output wr_en, wr_port, wr_pin, wr_dir, wr_data, rd_pin, rd_dir,
    input rd_data, out_opt, in_opt);
  modport mem (input wr_en, wr_port, wr_pin, wr_dir, wr_data, rd_pin, rd_dir,
    output rd_data, out_opt, in_opt);
endinterface
`default_nettype wire

// [src/ppoc_opt_mem.sv]
// per-pin option memory with registered readback
`timescale 1ns/1ps
`default_nettype none
module ppoc_opt_mem
  import ppoc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ppoc_opt_if.mem opt
);
  ppoc_out_type out_ff;
  ppoc_out_type nxt_out;
  ppoc_in_type in_ff;
  ppoc_in_type nxt_in;
  logic [NPORT-1:0][2:0] rd_ff;
  logic [NPORT-1:0][2:0] nxt_rd;

  always_comb
  begin
    nxt_out = out_ff;
    nxt_in = in_ff;
    if (opt.wr_en)
    begin
      if (opt.wr_dir == DIR_OUT)
        nxt_out[opt.wr_port][opt.wr_pin] = opt.wr_data;
      else
        nxt_in[opt.wr_port][opt.wr_pin] = opt.wr_data[1:0];
    end
    for (int p = 0; p < NPORT; p++)
    begin
      // input options read back with bit 7 zero
      if (opt.rd_dir[p] == DIR_IN)
        nxt_rd[p] = {1'b0, in_ff[p][opt.rd_pin[p]]};
      else
        nxt_rd[p] = out_ff[p][opt.rd_pin[p]];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_ff <= {NPORT*NPIN{OUT_RST}};
      in_ff <= {NPORT*NPIN{IN_RST}};
      rd_ff <= {NPORT{OUT_RST}};
    end
    else
    begin
      out_ff <= nxt_out;
      in_ff <= nxt_in;
      rd_ff <= nxt_rd;
    end
  end

  assign opt.out_opt = out_ff;
  assign opt.in_opt = in_ff;
  assign opt.rd_data = rd_ff;

  property p_out_wr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && opt.wr_dir == DIR_OUT) |=>
      out_ff[$past(opt.wr_port)][$past(opt.wr_pin)] == $past(opt.wr_data);
  endproperty
  a_out_wr: assert property (p_out_wr) else $error("output option not written");
  property p_in_wr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && opt.wr_dir == DIR_IN) |=>
      in_ff[$past(opt.wr_port)][$past(opt.wr_pin)] == $past(opt.wr_data[1:0]);
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("input option not written");
  property p_idle_keep;
    @(posedge ref_clk_i) disable iff (rst_i)
    !opt.wr_en |=> $stable(out_ff) && $stable(in_ff);
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("options changed without write");
endmodule // ppoc_opt_mem
`default_nettype wire

// [src/ppoc_pkg.sv]
// constants and types of the port pin option configuration block
// What this block does
// - direction flag 0 output, 1 input
// - load bit stores pin index and flag
// - load write leaves all options unchanged
// - plain write replaces addressed pin option
// - read returns pointed option in bits 7:5
// - pin index n selects pin n
// - four input options, pull-down code 01
// - flag steers write to input or output
// - output codes 000 normal, 011 high only
// - input option bits 6:5, order 00..11
`default_nettype none
package ppoc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] P0_CFG_IDX = 8'h9e;
  localparam logic [7:0] P1_CFG_IDX = 8'h9f;
  localparam int NPORT = 2;
  localparam int NPIN = 8;
  // write field positions
  localparam int FS_HI = 7;
  localparam int FS_LO = 5;
  localparam int DIR_BIT = 4;
  localparam int LOAD_BIT = 3;
  localparam int PIN_HI = 2;
  localparam int PIN_LO = 0;
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN = 1'b1;
  // option codes
  localparam logic [2:0] OUT_NORMAL = 3'h0;
  localparam logic [2:0] OUT_HIGH = 3'h3;
  localparam logic [1:0] IN_NOPULL = 2'h0;
  localparam logic [1:0] IN_PDOWN = 2'h1;
  localparam logic [1:0] IN_PUP = 2'h2;
  localparam logic [1:0] IN_OFF = 2'h3;
  // reset values
  localparam logic [2:0] OUT_RST = 3'h0;
  localparam logic [1:0] IN_RST = 2'h0;
  localparam logic [2:0] PIN_RST = 3'h0;
  localparam logic DIR_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RD_WAIT, ST_RD_LAST} ppoc_state_type;
  typedef logic [NPORT-1:0][NPIN-1:0][2:0] ppoc_out_type;
  typedef logic [NPORT-1:0][NPIN-1:0][1:0] ppoc_in_type;
endpackage
`default_nettype wire

// [src/ppoc_top.sv]
// ahb-lite slave for the two port pin option configuration registers
`timescale 1ns/1ps
`default_nettype none
module ppoc_top
  import ppoc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output ppoc_pkg::ppoc_out_type out_opt_o,
  output ppoc_pkg::ppoc_in_type in_opt_o
);
  import ppoc_pkg::*;

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic [31:0] byte_addr(input logic [7:0] idx);
    byte_addr = {22'h0, idx, 2'b00};
  endfunction

  // returns {mapped, port}
  function automatic logic [1:0] decode(input logic [31:0] addr);
    if (addr == byte_addr(P0_CFG_IDX))
      decode = 2'b10;
    else if (addr == byte_addr(P1_CFG_IDX))
      decode = 2'b11;
    else
      decode = 2'b00;
  endfunction

  ppoc_opt_if opt ();

  ppoc_opt_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .opt(opt)
  );

  // ************************************************************
  // bus phase tracking
  // ************************************************************
  ppoc_state_type state_ff;
  ppoc_state_type nxt_state;
  logic map_ff;
  logic nxt_map;
  logic port_ff;
  logic nxt_port;
  logic accept;
  logic [1:0] dec;

  assign accept = hsel_i && hready_i && htrans_i[1];
  assign dec = decode(haddr_i);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_map = map_ff;
    nxt_port = port_ff;
    case (state_ff)
      ST_RD_WAIT: nxt_state = ST_RD_LAST;
      default:
      begin
        if (accept)
        begin
          nxt_state = hwrite_i ? ST_WRITE : ST_RD_WAIT;
          nxt_map = dec[1];
          nxt_port = dec[0];
        end
        else
          nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      map_ff <= 1'b0;
      port_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      map_ff <= nxt_map;
      port_ff <= nxt_port;
    end
  end

  // ************************************************************
  // write handling and readback pointers
  // ************************************************************
  logic [NPORT-1:0][2:0] ptr_pin_ff;
  logic [NPORT-1:0][2:0] nxt_ptr_pin;
  logic [NPORT-1:0] ptr_dir_ff;
  logic [NPORT-1:0] nxt_ptr_dir;
  logic wr_live;
  logic load;

  assign wr_live = (state_ff == ST_WRITE) && map_ff;
  assign load = hwdata_i[LOAD_BIT];

  always_comb
  begin
    nxt_ptr_pin = ptr_pin_ff;
    nxt_ptr_dir = ptr_dir_ff;
    opt.wr_en = 1'b0;
    if (wr_live && load)
    begin
      nxt_ptr_pin[port_ff] = hwdata_i[PIN_HI:PIN_LO];
      nxt_ptr_dir[port_ff] = hwdata_i[DIR_BIT];
    end
    else if (wr_live)
      opt.wr_en = 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_pin_ff <= {NPORT{PIN_RST}};
      ptr_dir_ff <= {NPORT{DIR_RST}};
    end
    else
    begin
      ptr_pin_ff <= nxt_ptr_pin;
      ptr_dir_ff <= nxt_ptr_dir;
    end
  end

  assign opt.wr_port = port_ff;
  assign opt.wr_pin = hwdata_i[PIN_HI:PIN_LO];
  assign opt.wr_dir = hwdata_i[DIR_BIT];
  assign opt.wr_data = hwdata_i[FS_HI:FS_LO];
  assign opt.rd_pin = ptr_pin_ff;
  assign opt.rd_dir = ptr_dir_ff;

  // ************************************************************
  // read data and bus answer
  // ************************************************************
  // one wait state lets the registered readback catch up with a pointer
  // or option written by the transfer just before
  assign hreadyout_o = (state_ff != ST_RD_WAIT);
  assign hresp_o = 1'b0;

  always_comb
  begin
    hrdata_o = RDATA_RST;
    if (state_ff == ST_RD_LAST && map_ff)
      hrdata_o[FS_HI:FS_LO] = opt.rd_data[port_ff];
  end

  assign out_opt_o = opt.out_opt;
  assign in_opt_o = opt.in_opt;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_rd_wait;
    @(posedge ref_clk_i) disable iff (rst_i)
    (accept && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  property p_ptr_load;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && load) |=>
      ptr_pin_ff[$past(port_ff)] == $past(hwdata_i[PIN_HI:PIN_LO]) &&
      ptr_dir_ff[$past(port_ff)] == $past(hwdata_i[DIR_BIT]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_load_no_wr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && load) |-> !opt.wr_en;
  endproperty
  a_load_no_wr: assert property (p_load_no_wr) else $error("load write touched options");

  property p_plain_wr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && !load) |-> opt.wr_en ##1 ($stable(ptr_pin_ff) && $stable(ptr_dir_ff));
  endproperty
  a_plain_wr: assert property (p_plain_wr) else $error("plain write misrouted");

  property p_port_apart;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && port_ff == 1'b0) |=> $stable(ptr_pin_ff[1]) && $stable(ptr_dir_ff[1]);
  endproperty
  a_port_apart: assert property (p_port_apart) else $error("port 1 pointer disturbed");

  property p_rd_value;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_ff == ST_RD_LAST && map_ff) |->
      hrdata_o[FS_HI:FS_LO] == (ptr_dir_ff[port_ff] == DIR_IN ?
        {1'b0, opt.in_opt[port_ff][ptr_pin_ff[port_ff]]} :
        opt.out_opt[port_ff][ptr_pin_ff[port_ff]]);
  endproperty
  a_rd_value: assert property (p_rd_value) else $error("readback value wrong");

  property p_rd_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
    hrdata_o[31:8] == 24'h0 && hrdata_o[4:0] == 5'h0 && !hresp_o;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reserved read bits set");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (rst_i)
    (accept && !dec[1]) |=> !opt.wr_en && hrdata_o == RDATA_RST;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access acted");

  // a load write must leave every stored option as it was
  property p_load_keep;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && load) |=> $stable(opt.out_opt) && $stable(opt.in_opt);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("load write changed options");

  // pointers move only on a load write
  property p_ptr_keep;
    @(posedge ref_clk_i) disable iff (rst_i)
    !(wr_live && load) |=> $stable(ptr_pin_ff) && $stable(ptr_dir_ff);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer moved without load");

  property p_wr_nowait;
    @(posedge ref_clk_i) disable iff (rst_i)
    (accept && hwrite_i) |=> hreadyout_o;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");

  property p_rd_idle_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_ff != ST_RD_LAST || !map_ff) |-> hrdata_o == RDATA_RST;
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("stray read data");

  property p_dec_port;
    @(posedge ref_clk_i) disable iff (rst_i)
    (accept && haddr_i == byte_addr(P1_CFG_IDX)) |=> map_ff && port_ff == 1'b1;
  endproperty
  a_dec_port: assert property (p_dec_port) else $error("register on wrong port");

  property p_port1_apart;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_live && port_ff == 1'b1) |=> $stable(ptr_pin_ff[0]) && $stable(ptr_dir_ff[0]);
  endproperty
  a_port1_apart: assert property (p_port1_apart) else $error("port 0 pointer disturbed");

  // a write to one port must never reach the other port's options
  property p_opt_apart0;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && port_ff == 1'b0) |=> $stable(opt.out_opt[1]) && $stable(opt.in_opt[1]);
  endproperty
  a_opt_apart0: assert property (p_opt_apart0) else $error("port 1 options disturbed");

  property p_opt_apart1;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && port_ff == 1'b1) |=> $stable(opt.out_opt[0]) && $stable(opt.in_opt[0]);
  endproperty
  a_opt_apart1: assert property (p_opt_apart1) else $error("port 0 options disturbed");

  property p_out_wr_only;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && opt.wr_dir == DIR_OUT) |=> $stable(opt.in_opt);
  endproperty
  a_out_wr_only: assert property (p_out_wr_only) else $error("output write hit inputs");

  property p_in_wr_only;
    @(posedge ref_clk_i) disable iff (rst_i)
    (opt.wr_en && opt.wr_dir == DIR_IN) |=> $stable(opt.out_opt);
  endproperty
  a_in_wr_only: assert property (p_in_wr_only) else $error("input write hit outputs");

  property p_rd_wait_keep;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_ff == ST_RD_WAIT) |=>
      state_ff == ST_RD_LAST && $stable(port_ff) && $stable(map_ff);
  endproperty
  a_rd_wait_keep: assert property (p_rd_wait_keep) else $error("read answer lost target");

  // ************************************************************
  // covered scenarios
  // ************************************************************
  c_read: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    state_ff == ST_RD_LAST && map_ff && hrdata_o != RDATA_RST);
  c_load: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_live && load ##1 accept && !hwrite_i);
  c_in_wr: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    opt.wr_en && opt.wr_dir == DIR_IN && port_ff);
  c_out_high: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    opt.wr_en && opt.wr_dir == DIR_OUT && opt.wr_data == OUT_HIGH);
  c_rd_in: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    state_ff == ST_RD_LAST && map_ff && ptr_dir_ff[port_ff] == DIR_IN);
endmodule // ppoc_top
`default_nettype wire

// [tb/port_pin_option_config_tb_top.sv]
// self-checking bench for the port pin option configuration block
`timescale 1ns/1ps
`default_nettype none
module port_pin_option_config_tb_top;
  import ppoc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic hreadyout_o;
  logic hresp_o;
  logic [31:0] hrdata_o;
  ppoc_out_type out_opt_o;
  ppoc_in_type in_opt_o;
  int fail_count = 0;
  int checks = 0;
  int mo[2][8];
  int mi[2][8];
  int pp[2];
  int pd[2];
  logic [31:0] rd;
  logic [7:0] d;
  int rp;
  ppoc_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .out_opt_o(out_opt_o), .in_opt_o(in_opt_o));
  always #12.5 ref_clk_i = ~ref_clk_i;
  // ***********************
  // checking and closing
  // ***********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ***********************
  // bus master
  // ***********************
  // hready is looked at on the falling edge; it only moves after rising edges
  task automatic wait_rdy(output int n);
    n = 0;
    forever
    begin
      @(negedge ref_clk_i);
      chk(hresp_o, 1'b0);
      rd = hrdata_o;
      n++;
      if (n > 20)
      begin
        fail_count++;
        end_sim();
      end
      if (hreadyout_o === 1'b1)
        break;
    end
    @(posedge ref_clk_i);
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    hsize_i <= 3'h2;
    wait_rdy(n);
    chk(n, 1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= w ? wd : 32'h0;
    wait_rdy(n);
    chk(n, w ? 1 : 2);
  endtask
  function automatic logic [31:0] adr(input int p);
    return {22'h0, (p == 0) ? P0_CFG_IDX : P1_CFG_IDX, 2'b00};
  endfunction
  // ***********************
  // model and compares
  // ***********************
  task automatic chk_opts();
    #1;
    for (int p = 0; p < 2; p++)
      for (int n = 0; n < 8; n++)
      begin
        chk(32'(out_opt_o[p][n]), mo[p][n]);
        chk(32'(in_opt_o[p][n]), mi[p][n]);
      end
  endtask
  task automatic do_wr(input int p, input logic [7:0] v);
    xfer(adr(p), 1'b1, {24'h0, v});
    if (v[LOAD_BIT])
    begin
      pp[p] = v[2:0];
      pd[p] = v[DIR_BIT];
    end
    else if (v[DIR_BIT])
      mi[p][v[2:0]] = v[6:5];
    else
      mo[p][v[2:0]] = v[7:5];
    chk_opts();
  endtask
  task automatic do_rd(input int p);
    xfer(adr(p), 1'b0, 32'h0);
    chk(rd, (pd[p] != 0 ? mi[p][pp[p]] : mo[p][pp[p]]) << 5);
  endtask
  function automatic logic [2:0] rnd_set(input logic dir);
    // only legal output codes are written, illegal ones are software's fault
    return dir ? 3'($urandom) : (($urandom % 2) ? OUT_HIGH : OUT_NORMAL);
  endfunction
  // ***********************
  // tests
  // ***********************
  initial
  begin
    #(25 * 20000);
    fail_count++;
    end_sim();
  end
  initial
  begin
    void'($urandom(4028));
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (mo[p, n])
    begin
      mo[p][n] = 0;
      mi[p][n] = 0;
    end
    pp = '{0, 0};
    pd = '{0, 0};
    chk_opts();
    do_rd(0);
    do_rd(1);
    // every pin, both directions, every input code in turn
    for (int p = 0; p < 2; p++)
      for (int n = 0; n < 8; n++)
      begin
        do_wr(p, {rnd_set(1'b0), DIR_OUT, 1'b0, 3'(n)});
        do_wr(p, {1'(n), 2'(n + p), DIR_IN, 1'b0, 3'(n)});
      end
    // pointer loads carry junk settings which must be ignored
    for (int p = 0; p < 2; p++)
      for (int n = 0; n < 8; n++)
        for (int r = 0; r < 2; r++)
        begin
          do_wr(p, {3'($urandom), 1'(r), 1'b1, 3'(n)});
          do_rd(p);
        end
    // pointers and options stay apart per port
    do_wr(0, {3'h0, DIR_IN, 1'b1, 3'h3});
    do_wr(1, {3'h2, DIR_IN, 1'b0, 3'h3});
    do_rd(0);
    do_rd(1);
    // unmapped address: write ignored, read zero
    xfer(32'h280, 1'b1, 32'h0000_00e7);
    chk_opts();
    xfer(32'h280, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // random mixed traffic, reads right after writes
    repeat (300)
    begin
      rp = $urandom % 2;
      d[4] = 1'($urandom);
      d = {rnd_set(d[4]), d[4], 1'($urandom), 3'($urandom)};
      // random traffic on port 0 stays off pin 7, which small packages lack
      if (rp == 0 && d[2:0] == 3'h7)
        d[2:0] = 3'h6;
      do_wr(rp, d);
      do_rd($urandom % 2);
    end
    end_sim();
  end
endmodule // port_pin_option_config_tb_top
`default_nettype wire
